// file: hw_monitor_pkg.sv
// Constants, register map and carrier types of the hardware monitor sequencer.
// Assumes a single 250 MHz clock and a converter that returns one sample per done pulse.
//
// Functional notes
// - Cycle mode: one full pass, then idle, restart every second, never over 1.4 s.
// - Monitoring starts only when the host writes one to configuration bit 0.
// - Every pass averages each input once in the fixed round-robin order, skipping 12 V while configuration bit 5 is set.
// - Each result is compared to its high and low limits; equal counts as violation.
// - Stored results are readable anytime; in cycle mode they change once per pass.
// - Each status flag is rewritten every pass its channel is converted: zero inside limits and no fault.
// - Reading a status register never clears or changes any flag.
// - Both status registers read zero after power-on reset and after soft reset.
// - Configuration zero means low power; special function bit 0 picks the kind.
// - Entering sleep or shutdown resets no register.
// - Low power stops converter and pass; registers remain readable and writable.
// - Supply channels except processor voltage read 192 at nominal supply.
// - Voltage codes are 8-bit unsigned, saturating at all zeros and all ones.
// - Voltage-code inputs 3..0 go to 0x47 bits 3..0, input 4 to 0x49 bit 0.
// - Fifth voltage-code pin is analog and reads zero until configuration bit 5.
// - Internal temperature stored at 0x27, checked against limits 0x39 and 0x3A.
// - Remote diode one stored at 0x26, two at 0x52, each with own limits.
// - Diode open or short is tested before update and flagged in 0x42.
// - Temperatures are 8-bit two's complement, one degree per step.
// - Order: remote one, internal, standby, 12 V, 5, 3.3, 2.5, processor, remote two, 1.8, 1.5.
// - Special function bit 1 selects continuous or cycle monitoring.
// - Special function bit 5 selects 128/8 or 16/1 samples averaged.
package hw_monitor_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_FREQ_MHZ = 250;
  localparam int unsigned PASS_PERIOD_MS = 1000;
  localparam int unsigned PASS_PERIOD_MAX_MS = 1400;
  // One second sits well inside the 1.4 s bound.
  localparam int unsigned PASS_PERIOD_CYCLES = PASS_PERIOD_MS * 1000 * CLK_FREQ_MHZ;
  localparam int unsigned PERIOD_CNT_W = 28;

  // ************************************************************
  // Channels in sampling order
  // ************************************************************
  localparam int unsigned NUM_CHAN = 11;
  localparam logic [3:0] CH_REMOTE_ONE = 4'h0;
  localparam logic [3:0] CH_INTERNAL = 4'h1;
  localparam logic [3:0] CH_TWELVE = 4'h3;
  localparam logic [3:0] CH_REMOTE_TWO = 4'h8;
  localparam logic [3:0] CH_LAST = 4'hA;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] VALUE_OFS [NUM_CHAN] = '{8'h26, 8'h27, 8'h25, 8'h24, 8'h23, 8'h22,
                                                 8'h20, 8'h21, 8'h52, 8'h53, 8'h54};
  localparam logic [7:0] HIGH_OFS [NUM_CHAN] = '{8'h37, 8'h39, 8'h2B, 8'h2D, 8'h2F, 8'h31,
                                                8'h33, 8'h35, 8'h55, 8'h57, 8'h59};
  localparam logic [7:0] LOW_OFS [NUM_CHAN] = '{8'h38, 8'h3A, 8'h2C, 8'h2E, 8'h30, 8'h32,
                                               8'h34, 8'h36, 8'h56, 8'h58, 8'h5A};
  localparam logic [7:0] CONFIG_OFS = 8'h40;
  localparam logic [7:0] STATUS_ONE_OFS = 8'h41;
  localparam logic [7:0] STATUS_TWO_OFS = 8'h42;
  localparam logic [7:0] VCODE_LOW_OFS = 8'h47;
  localparam logic [7:0] VCODE_HIGH_OFS = 8'h49;
  localparam logic [7:0] SPECIAL_OFS = 8'h4F;

  // Bit of the 16-bit status pair (status one low byte) for each channel.
  localparam logic [3:0] STAT_BIT [NUM_CHAN] = '{4'h5, 4'h4, 4'h8, 4'h6, 4'h3, 4'h2,
                                                4'h0, 4'h1, 4'h7, 4'h9, 4'hA};
  localparam logic [3:0] FAULT_ONE_BIT = 4'hB;
  localparam logic [3:0] FAULT_TWO_BIT = 4'hC;

  localparam int unsigned CFG_START_BIT = 0;
  localparam int unsigned CFG_FIFTH_VOLTAGE_CODE_INPUT_SEL_BIT = 5;
  localparam int unsigned CFG_SOFT_RESET_BIT = 7;
  localparam int unsigned SFR_SHUTDOWN_BIT = 0;
  localparam int unsigned SFR_CYCLE_BIT = 1;
  localparam int unsigned SFR_FAST_BIT = 5;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] SPECIAL_RESET = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0] READING_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic done;
    logic [7:0] code;
    logic diode_fault;
  } conv_result_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_GAP = 2'b10
  } seq_state_t;

  // ************************************************************
  // Channel helpers
  // ************************************************************
  function automatic logic is_remote(input logic [3:0] ch);
    return (ch == CH_REMOTE_ONE) || (ch == CH_REMOTE_TWO);
  endfunction : is_remote

  function automatic logic is_temp(input logic [3:0] ch);
    return is_remote(ch) || (ch == CH_INTERNAL);
  endfunction : is_temp

  // Log2 of the number of samples averaged for a channel.
  function automatic logic [2:0] avg_shift(input logic [3:0] ch, input logic fast);
    if (is_remote(ch)) begin
      return fast ? 3'h4 : 3'h7;
    end
    return fast ? 3'h0 : 3'h3;
  endfunction : avg_shift

endpackage : hw_monitor_pkg

// file: hw_monitor_sequencer.sv
// Sequencer, averaging, limit checking and register file of the hardware monitor.
// Assumes a register port fed by the serial bus slave and a converter that
// answers each sample of the requested channel with one done pulse.
module hw_monitor_sequencer #(
  parameter int unsigned PASS_PERIOD = hw_monitor_pkg::PASS_PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire hw_monitor_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire hw_monitor_pkg::conv_result_t conv_result,
  output logic conv_req,
  output logic [3:0] conv_chan,
  input wire logic [4:0] processor_voltage_code_inputs,
  output logic twelve_volt_pin_is_code,
  output logic sleep_active,
  output logic shutdown_active
);

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] value_q [hw_monitor_pkg::NUM_CHAN];
  logic [7:0] high_q [hw_monitor_pkg::NUM_CHAN];
  logic [7:0] low_q [hw_monitor_pkg::NUM_CHAN];
  logic [7:0] config_q;
  logic [7:0] special_q;
  logic [15:0] status_q;
  logic [3:0] vcode_low_q;
  logic [3:0] vcode_ctl_q;
  logic vcode_high_q;
  logic [7:0] rdata_q;
  hw_monitor_pkg::seq_state_t state_q;
  logic [3:0] chan_q;
  logic req_q;
  logic [15:0] accum_q;
  logic [7:0] sample_cnt_q;
  logic fault_q;
  logic [hw_monitor_pkg::PERIOD_CNT_W-1:0] period_q;
  logic sleep_q;
  logic shutdown_q;
  logic pin_code_q;

  // ************************************************************
  // Register write decode
  // ************************************************************
  wire cfg_wr = reg_req.wr && (reg_req.addr == hw_monitor_pkg::CONFIG_OFS);
  wire sfr_wr = reg_req.wr && (reg_req.addr == hw_monitor_pkg::SPECIAL_OFS);
  wire vcode_wr = reg_req.wr && (reg_req.addr == hw_monitor_pkg::VCODE_LOW_OFS);
  // Soft reset is a write with bit 7 set; the bit itself is never stored.
  wire soft_reset = cfg_wr && reg_req.wdata[hw_monitor_pkg::CFG_SOFT_RESET_BIT];
  wire run = config_q[hw_monitor_pkg::CFG_START_BIT];
  wire cycle_mode = special_q[hw_monitor_pkg::SFR_CYCLE_BIT];
  wire fast_mode = special_q[hw_monitor_pkg::SFR_FAST_BIT];
  wire fifth_voltage_code_input_sel = config_q[hw_monitor_pkg::CFG_FIFTH_VOLTAGE_CODE_INPUT_SEL_BIT];

  // ************************************************************
  // Averaging and limit compare
  // ************************************************************
  wire [2:0] shift = hw_monitor_pkg::avg_shift(chan_q, fast_mode);
  wire chan_temp = hw_monitor_pkg::is_temp(chan_q);
  wire chan_remote = hw_monitor_pkg::is_remote(chan_q);
  wire [7:0] last_cnt = 8'((16'h0001 << shift) - 16'h0001);
  // Temperatures are signed and extend their sign; voltages are unsigned codes.
  wire [15:0] sample_ext = chan_temp ? {{8{conv_result.code[7]}}, conv_result.code}
                                     : {8'h00, conv_result.code};
  wire [15:0] total = accum_q + sample_ext;
  wire signed [15:0] total_s = total;
  wire [15:0] shifted = 16'(total_s >>> shift);
  // The mean of saturated 8-bit codes stays within 8 bits, so saturation is kept.
  wire [7:0] average = shifted[7:0];
  wire last_sample = conv_result.done && (state_q == hw_monitor_pkg::ST_CONV)
                     && (sample_cnt_q == last_cnt);
  wire fault_now = chan_remote && (fault_q || conv_result.diode_fault);
  wire [7:0] hi_lim = high_q[chan_q];
  wire [7:0] lo_lim = low_q[chan_q];
  // Equal to a limit counts as a violation.
  wire above = chan_temp ? ($signed(average) >= $signed(hi_lim)) : (average >= hi_lim);
  wire below = chan_temp ? ($signed(average) <= $signed(lo_lim)) : (average <= lo_lim);
  wire flag = above || below || fault_now;
  // A result is stored only when its pass is still running.
  wire store = last_sample && run && !soft_reset;

  // ************************************************************
  // Channel order
  // ************************************************************
  // The 12 V slot is skipped while its pin serves as the fifth code input.
  wire [3:0] chan_inc = chan_q + 4'h1;
  wire [3:0] next_chan = ((chan_inc == hw_monitor_pkg::CH_TWELVE) && fifth_voltage_code_input_sel) ?
                         (chan_inc + 4'h1) : chan_inc;
  wire pass_end = chan_q == hw_monitor_pkg::CH_LAST;
  wire period_done = period_q >= hw_monitor_pkg::PERIOD_CNT_W'(PASS_PERIOD - 1);

  // ************************************************************
  // Read mux
  // ************************************************************
  logic [7:0] rd_mux;
  // Reads have no side effect on any flag.
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < hw_monitor_pkg::NUM_CHAN; i++) begin
      if (reg_req.addr == hw_monitor_pkg::VALUE_OFS[i]) begin
        rd_mux = value_q[i];
      end
      if (reg_req.addr == hw_monitor_pkg::HIGH_OFS[i]) begin
        rd_mux = high_q[i];
      end
      if (reg_req.addr == hw_monitor_pkg::LOW_OFS[i]) begin
        rd_mux = low_q[i];
      end
    end
    case (reg_req.addr)
      hw_monitor_pkg::CONFIG_OFS: rd_mux = config_q;
      hw_monitor_pkg::STATUS_ONE_OFS: rd_mux = status_q[7:0];
      hw_monitor_pkg::STATUS_TWO_OFS: rd_mux = status_q[15:8];
      hw_monitor_pkg::VCODE_LOW_OFS: rd_mux = {vcode_ctl_q, vcode_low_q};
      hw_monitor_pkg::VCODE_HIGH_OFS: rd_mux = {7'h00, vcode_high_q};
      hw_monitor_pkg::SPECIAL_OFS: rd_mux = special_q;
      default: rd_mux = rd_mux;
    endcase
  end

  // Read data is registered; it appears one cycle after the read strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      rdata_q <= rd_mux;
    end
  end

  // ************************************************************
  // Configuration and special function registers
  // ************************************************************
  // Low power never touches other registers; they stay writable through it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      config_q <= hw_monitor_pkg::CONFIG_RESET;
      special_q <= hw_monitor_pkg::SPECIAL_RESET;
      vcode_ctl_q <= 4'h0;
    end else if (soft_reset) begin
      config_q <= hw_monitor_pkg::CONFIG_RESET;
      special_q <= hw_monitor_pkg::SPECIAL_RESET;
      vcode_ctl_q <= 4'h0;
    end else begin
      if (cfg_wr) begin
        config_q <= reg_req.wdata;
      end
      if (sfr_wr) begin
        special_q <= reg_req.wdata;
      end
      if (vcode_wr) begin
        vcode_ctl_q <= reg_req.wdata[7:4];
      end
    end
  end

  // ************************************************************
  // Limit registers
  // ************************************************************
  // Limits survive soft reset; only power-on reset clears them.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < hw_monitor_pkg::NUM_CHAN; i++) begin
        high_q[i] <= hw_monitor_pkg::LIMIT_RESET;
        low_q[i] <= hw_monitor_pkg::LIMIT_RESET;
      end
    end else begin
      for (int i = 0; i < hw_monitor_pkg::NUM_CHAN; i++) begin
        if (reg_req.wr && (reg_req.addr == hw_monitor_pkg::HIGH_OFS[i])) begin
          high_q[i] <= reg_req.wdata;
        end
        if (reg_req.wr && (reg_req.addr == hw_monitor_pkg::LOW_OFS[i])) begin
          low_q[i] <= reg_req.wdata;
        end
      end
    end
  end

  // ************************************************************
  // Readings
  // ************************************************************
  // A faulty remote diode keeps its previous reading; only the flags show the fault.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < hw_monitor_pkg::NUM_CHAN; i++) begin
        value_q[i] <= hw_monitor_pkg::READING_RESET;
      end
    end else if (store && !fault_now) begin
      value_q[chan_q] <= average;
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  // A soft reset aborts the pass, so it beats a store in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= hw_monitor_pkg::STATUS_RESET;
    end else if (soft_reset) begin
      status_q <= hw_monitor_pkg::STATUS_RESET;
    end else if (store) begin
      status_q[hw_monitor_pkg::STAT_BIT[chan_q]] <= flag;
      if (chan_q == hw_monitor_pkg::CH_REMOTE_ONE) begin
        status_q[hw_monitor_pkg::FAULT_ONE_BIT] <= fault_now;
      end
      if (chan_q == hw_monitor_pkg::CH_REMOTE_TWO) begin
        status_q[hw_monitor_pkg::FAULT_TWO_BIT] <= fault_now;
      end
    end
  end

  // ************************************************************
  // Voltage code capture
  // ************************************************************
  // The fifth input reads zero while its pin is the analog 12 V input.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vcode_low_q <= 4'h0;
      vcode_high_q <= 1'b0;
      pin_code_q <= 1'b0;
    end else begin
      vcode_low_q <= processor_voltage_code_inputs[3:0];
      vcode_high_q <= fifth_voltage_code_input_sel && processor_voltage_code_inputs[4];
      pin_code_q <= fifth_voltage_code_input_sel;
    end
  end

  // ************************************************************
  // Pass sequencer
  // ************************************************************
  // Clearing start aborts at once and drops the partial sum.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= hw_monitor_pkg::ST_IDLE;
      chan_q <= hw_monitor_pkg::CH_REMOTE_ONE;
      req_q <= 1'b0;
      accum_q <= 16'h0000;
      sample_cnt_q <= 8'h00;
      fault_q <= 1'b0;
      period_q <= '0;
    end else if (!run || soft_reset) begin
      state_q <= hw_monitor_pkg::ST_IDLE;
      chan_q <= hw_monitor_pkg::CH_REMOTE_ONE;
      req_q <= 1'b0;
      accum_q <= 16'h0000;
      sample_cnt_q <= 8'h00;
      fault_q <= 1'b0;
      period_q <= '0;
    end else begin
      if (!period_done) begin
        period_q <= period_q + hw_monitor_pkg::PERIOD_CNT_W'(1);
      end
      case (state_q)
        hw_monitor_pkg::ST_IDLE: begin
          state_q <= hw_monitor_pkg::ST_CONV;
          chan_q <= hw_monitor_pkg::CH_REMOTE_ONE;
          req_q <= 1'b1;
          period_q <= '0;
        end
        hw_monitor_pkg::ST_CONV: begin
          if (conv_result.done && !last_sample) begin
            accum_q <= total;
            sample_cnt_q <= sample_cnt_q + 8'h01;
            fault_q <= fault_q || conv_result.diode_fault;
          end else if (last_sample) begin
            accum_q <= 16'h0000;
            sample_cnt_q <= 8'h00;
            fault_q <= 1'b0;
            if (!pass_end) begin
              chan_q <= next_chan;
            end else if (cycle_mode) begin
              state_q <= hw_monitor_pkg::ST_GAP;
              req_q <= 1'b0;
            end else begin
              chan_q <= hw_monitor_pkg::CH_REMOTE_ONE;
            end
          end
        end
        hw_monitor_pkg::ST_GAP: begin
          // The period runs from pass start, so passes repeat every second.
          if (period_done) begin
            state_q <= hw_monitor_pkg::ST_CONV;
            chan_q <= hw_monitor_pkg::CH_REMOTE_ONE;
            req_q <= 1'b1;
            period_q <= '0;
          end
        end
        default: begin
          state_q <= hw_monitor_pkg::ST_IDLE;
          req_q <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Low power indication
  // ************************************************************
  // Start clear means low power; the select bit picks sleep (0) or shutdown (1).
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleep_q <= 1'b0;
      shutdown_q <= 1'b0;
    end else begin
      sleep_q <= !run && !special_q[hw_monitor_pkg::SFR_SHUTDOWN_BIT];
      shutdown_q <= !run && special_q[hw_monitor_pkg::SFR_SHUTDOWN_BIT];
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata = rdata_q;
  assign conv_req = req_q;
  assign conv_chan = chan_q;
  assign twelve_volt_pin_is_code = pin_code_q;
  assign sleep_active = sleep_q;
  assign shutdown_active = shutdown_q;

endmodule : hw_monitor_sequencer

// file: hw_monitor_sequencer_asserts.sv
// Port checker of the monitor sequencer.
// Assumes the bind at the foot attaches it.
module hw_monitor_sequencer_asserts #(
  parameter int unsigned PASS_PERIOD = 2000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire hw_monitor_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire hw_monitor_pkg::conv_result_t conv_result,
  input wire logic conv_req,
  input wire logic [3:0] conv_chan,
  input wire logic [4:0] processor_voltage_code_inputs,
  input wire logic twelve_volt_pin_is_code,
  input wire logic sleep_active,
  input wire logic shutdown_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****
  // Helpers
  // ****
  // The idle counter restarts in low power, where no pass is owed.
  logic [31:0] gap_q;
  wire low_pw = sleep_active | shutdown_active;
  wire cfg_wr = reg_req.wr && (reg_req.addr == hw_monitor_pkg::CONFIG_OFS);
  wire [31:0] gap_d = (conv_req || low_pw) ? 32'h0000_0000 : gap_q + 32'h0000_0001;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 32'h0000_0000;
    end else begin
      gap_q <= gap_d;
    end
  end
  // ****
  // Properties
  // ****
  // The write-driven ones tie an output to its cause at an exact cycle; the rest are invariants.
  a_gap_bounded: assert property (gap_q <= PASS_PERIOD)
    else $error("pass gap too long");
  a_start_to_req: assert property (low_pw && cfg_wr && reg_req.wdata[0]
    && !reg_req.wdata[7] ##1 !cfg_wr |-> ##1 conv_req)
    else $error("start began no pass");
  a_first_chan_zero: assert property ($rose(conv_req) |-> conv_chan == 4'h0)
    else $error("pass began off channel 0");
  a_chan_in_range: assert property (conv_req |-> conv_chan <= hw_monitor_pkg::CH_LAST)
    else $error("channel out of range");
  a_chan_step_order: assert property (conv_req && $past(conv_req) && $changed(conv_chan)
    |-> $past(conv_result.done) && ((conv_chan == $past(conv_chan) + 4'h1)
    || (conv_chan == 4'h4 && $past(conv_chan) == 4'h2)
    || (conv_chan == 4'h0 && $past(conv_chan) == 4'hA)))
    else $error("channel order broken");
  a_power_exclusive: assert property (!(sleep_active && shutdown_active))
    else $error("sleep with shutdown");
  a_low_power_idle: assert property (low_pw |-> !conv_req)
    else $error("request in low power");
  a_enter_low_power: assert property (!low_pw && cfg_wr && reg_req.wdata == 8'h00
    ##1 !cfg_wr |-> ##1 low_pw && !conv_req)
    else $error("low power not entered");
  a_code_pin_select: assert property (cfg_wr && !reg_req.wdata[7] ##1 !cfg_wr
    |-> ##1 twelve_volt_pin_is_code == $past(reg_req.wdata[5], 2))
    else $error("pin select wrong");
  a_rdata_holds: assert property (!$past(reg_req.rd) |-> $stable(reg_rdata))
    else $error("read data moved unread");
  c_pass_start: cover property ($rose(conv_req));
  c_cycle_gap: cover property ($fell(conv_req) && !low_pw);
  c_shutdown: cover property (shutdown_active);
  c_code_pin: cover property (twelve_volt_pin_is_code);
endmodule : hw_monitor_sequencer_asserts

bind hw_monitor_sequencer hw_monitor_sequencer_asserts #(.PASS_PERIOD(PASS_PERIOD)) u_asserts (
  .clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .conv_result(conv_result), .conv_req(conv_req), .conv_chan(conv_chan),
  .processor_voltage_code_inputs(processor_voltage_code_inputs),
  .twelve_volt_pin_is_code(twelve_volt_pin_is_code), .sleep_active(sleep_active),
  .shutdown_active(shutdown_active));

// file: converter_model.sv
// Behavioural converter answering the sequencer's sample requests.
// Assumes codes and faults come from the bench.
module converter_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic conv_req,
  input wire logic [3:0] conv_chan,
  input wire logic [7:0] chan_code [11],
  input wire logic [10:0] fault_mask,
  output hw_monitor_pkg::conv_result_t conv_result
);
  logic done_q;
  logic slow_q;
  logic [1:0] wait_q;
  logic [7:0] code_q;
  logic fault_q;
  // Answers alternate between prompt and three cycles late.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {done_q, slow_q, wait_q, code_q, fault_q} <= '0;
    end else begin
      done_q <= 1'b0;
      if (conv_req && !done_q && wait_q == 2'h0) begin
        done_q <= 1'b1;
        code_q <= chan_code[conv_chan];
        fault_q <= fault_mask[conv_chan];
        slow_q <= !slow_q;
        wait_q <= slow_q ? 2'h0 : 2'h3;
      end else if (conv_req && !done_q) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end
  // Between done pulses the data lines show the inverse.
  assign conv_result = '{done: done_q, code: done_q ? code_q : ~code_q,
                         diode_fault: done_q ? fault_q : ~fault_q};
endmodule : converter_model

// file: hw_monitor_sequencer_tb.sv
// Self-checking bench of the monitor sequencer with a converter model.
// Assumes the checker is bound in its own file.
module hw_monitor_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PERIOD = 2000;
  localparam logic [7:0] CODES [11] = '{8'hd8, 8'h19, 8'hc0, 8'hc0, 8'hff, 8'h00,
                                        8'hc0, 8'h5a, 8'h7d, 8'hc0, 8'hc0};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  hw_monitor_pkg::reg_req_t reg_req = '0;
  hw_monitor_pkg::conv_result_t conv_result;
  logic [7:0] reg_rdata;
  logic conv_req;
  logic [3:0] conv_chan;
  logic [4:0] vcode = 5'h1a;
  logic [10:0] fault = 11'h000;
  logic tv;
  logic slp;
  logic sdn;
  logic [3:0] order [$];
  int error_cnt = 0;
  int checked = 0;
  always #2 clk = ~clk;
  hw_monitor_sequencer #(.PASS_PERIOD(PERIOD)) dut (.clk(clk), .rstn(rstn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .conv_result(conv_result),
    .conv_req(conv_req), .conv_chan(conv_chan), .processor_voltage_code_inputs(vcode),
    .twelve_volt_pin_is_code(tv), .sleep_active(slp), .shutdown_active(sdn));
  converter_model cnv (.clk(clk), .rstn(rstn), .conv_req(conv_req), .conv_chan(conv_chan),
    .chan_code(CODES), .fault_mask(fault), .conv_result(conv_result));
  // Channel order is logged mid-cycle, away from the changing edge.
  always @(negedge clk) begin
    if (conv_req && conv_result.done && (order.size() == 0 || order[$] != conv_chan)) begin
      order.push_back(conv_chan);
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask : check
  // Accesses run falling edge to falling edge, then idle a cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    reg_req.wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    reg_req.rd = 1'b0;
    check(reg_rdata, exp);
    @(negedge clk);
  endtask : rdc
  task automatic wait_req(input logic lvl);
    int n = 0;
    while (conv_req !== lvl && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(n < 3000, 1'b1);
  endtask : wait_req
  task automatic t_reset();
    rdc(hw_monitor_pkg::STATUS_ONE_OFS, 8'h00);
    rdc(hw_monitor_pkg::STATUS_TWO_OFS, 8'h00);
    check(slp, 1'b1);
    rdc(hw_monitor_pkg::VCODE_LOW_OFS, 8'h0a);
    rdc(hw_monitor_pkg::VCODE_HIGH_OFS, 8'h00);
  endtask : t_reset
  task automatic t_pass();
    logic [15:0] st;
    logic [7:0] h;
    logic [7:0] l;
    int n = 0;
    st = 16'h0000;
    st[hw_monitor_pkg::FAULT_TWO_BIT] = 1'b1;
    fault = 11'h100;
    for (int c = 0; c < 11; c++) begin
      h = CODES[c] + ((c == 2) ? 8'h00 : 8'h01);
      l = CODES[c] - 8'h01;
      wr(hw_monitor_pkg::HIGH_OFS[c], h);
      wr(hw_monitor_pkg::LOW_OFS[c], l);
      st[hw_monitor_pkg::STAT_BIT[c]] = (c == 0 || c == 1 || c == 8) ? (fault[c]
        || ($signed(CODES[c]) >= $signed(h)) || ($signed(CODES[c]) <= $signed(l)))
        : ((CODES[c] >= h) || (CODES[c] <= l));
    end
    wr(hw_monitor_pkg::SPECIAL_OFS, 8'h22);
    order.delete();
    wr(hw_monitor_pkg::CONFIG_OFS, 8'h01);
    wait_req(1'b0);
    check(order.size(), 16'h000b);
    for (int i = 0; i < 11; i++) check(order[i], i);
    while (!conv_req && n < 2 * PERIOD) begin
      @(negedge clk);
      n++;
    end
    check(n > 0 && n < PERIOD, 1'b1);
    for (int c = 0; c < 11; c++) begin
      rdc(hw_monitor_pkg::VALUE_OFS[c], (c == 8) ? 8'h00 : CODES[c]);
    end
    rdc(hw_monitor_pkg::STATUS_ONE_OFS, st[7:0]);
    rdc(hw_monitor_pkg::STATUS_TWO_OFS, st[15:8]);
    rdc(hw_monitor_pkg::STATUS_ONE_OFS, st[7:0]);
  endtask : t_pass
  task automatic t_low_power();
    wr(hw_monitor_pkg::SPECIAL_OFS, 8'h23);
    wr(hw_monitor_pkg::CONFIG_OFS, 8'h00);
    check(sdn, 1'b1);
    repeat (PERIOD + 20) @(negedge clk);
    check(conv_req, 1'b0);
    wr(hw_monitor_pkg::HIGH_OFS[1], 8'h55);
    rdc(hw_monitor_pkg::HIGH_OFS[1], 8'h55);
    rdc(hw_monitor_pkg::VALUE_OFS[1], CODES[1]);
    rdc(hw_monitor_pkg::SPECIAL_OFS, 8'h23);
  endtask : t_low_power
  task automatic t_code_pin();
    wr(hw_monitor_pkg::SPECIAL_OFS, 8'h20);
    order.delete();
    wr(hw_monitor_pkg::CONFIG_OFS, 8'h21);
    check(tv, 1'b1);
    rdc(hw_monitor_pkg::VCODE_HIGH_OFS, 8'h01);
    while (order.size() < 11) @(negedge clk);
    check(conv_req, 1'b1);
    for (int i = 0; i < 11; i++) check(order[i], (i < 3) ? i : ((i < 10) ? i + 1 : 0));
  endtask : t_code_pin
  task automatic t_soft_reset();
    wr(hw_monitor_pkg::CONFIG_OFS, 8'h80);
    rdc(hw_monitor_pkg::STATUS_ONE_OFS, 8'h00);
    rdc(hw_monitor_pkg::STATUS_TWO_OFS, 8'h00);
    rdc(hw_monitor_pkg::VALUE_OFS[0], CODES[0]);
    check(slp, 1'b1);
  endtask : t_soft_reset
  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_reset();
    t_pass();
    t_low_power();
    t_code_pin();
    t_soft_reset();
    complete_run();
  end
  // A run needs under 8000 cycles; 20000 cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
endmodule : hw_monitor_sequencer_tb
